// file: test/dsps_chk.sv
`timescale 1ns/1ps
module dsps_chk #(
   parameter DQ_W   = 8,
   parameter CODE_W = 5
)(
   input wire              core_clk,
   input wire              resetn,
   input wire              ref_clk_top,
   input wire              ref_clk_bot,
   input wire              out_valid,
   input wire              out_ready,
   input wire [2*DQ_W-1:0] out_data,
   input wire              cap_ready_q,
   input wire              overflow_q,
   input wire              lock_top_q,
   input wire              lock_bot_q,
   input wire [CODE_W-1:0] code_top_q,
   input wire [CODE_W-1:0] code_bot_q
);
   // Counts reference rises seen while that edge is still unlocked.
   reg [9:0] n_top_q;
   reg [9:0] n_bot_q;
   reg       rt_q;
   reg       rb_q;
   always @(posedge core_clk)
   begin
      rt_q <= ref_clk_top;
      rb_q <= ref_clk_bot;
      if (!resetn)
      begin
         n_top_q <= 10'h000;
         n_bot_q <= 10'h000;
      end
      else
      begin
         if (ref_clk_top && !rt_q && !lock_top_q)
            n_top_q <= n_top_q + 10'h001;
         if (ref_clk_bot && !rb_q && !lock_bot_q)
            n_bot_q <= n_bot_q + 10'h001;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   code_top_step_a:
   assert property ($changed(code_top_q) |-> code_top_q == $past(code_top_q) + 1'b1
      || code_top_q + 1'b1 == $past(code_top_q)) else $error("top code jump");
   code_bot_step_a:
   assert property ($changed(code_bot_q) |-> code_bot_q == $past(code_bot_q) + 1'b1
      || code_bot_q + 1'b1 == $past(code_bot_q)) else $error("bottom code jump");
   sticky_flags_a:
   assert property (!$fell(lock_top_q) && !$fell(lock_bot_q) && !$fell(overflow_q))
      else $error("sticky flag fell");
   lock_top_time_a:
   assert property (n_top_q < 10'h101) else $error("top lock late");
   lock_bot_time_a:
   assert property (n_bot_q < 10'h101) else $error("bottom lock late");
   data_hold_a:
   assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output word not held");
   drop_full_a:
   assert property ($rose(overflow_q) |-> !cap_ready_q) else $error("drop while not full");
   full_valid_a:
   assert property ($fell(cap_ready_q) |-> out_valid) else $error("full but no output");
endmodule

bind dsps_top dsps_chk #(.DQ_W(DQ_W), .CODE_W(CODE_W)) u_dsps_chk (
   .core_clk, .resetn, .ref_clk_top, .ref_clk_bot, .out_valid, .out_ready, .out_data,
   .cap_ready_q, .overflow_q, .lock_top_q, .lock_bot_q, .code_top_q, .code_bot_q
);

// file: test/dsps_mem.sv
`timescale 1ns/1ps
module dsps_mem (
   input  wire        core_clk,
   output reg  [9:0]  dqs_top,
   output reg  [9:0]  dqs_bot,
   output reg  [79:0] dq_top,
   output reg  [79:0] dq_bot,
   output reg  [7:0]  dq_side,
   output reg         ref_clk_side
);
   initial
   begin
      dqs_top = 10'h000;
      dqs_bot = 10'h000;
      dq_top = 80'h0;
      dq_bot = 80'h0;
      dq_side = 8'h00;
      ref_clk_side = 1'b0;
   end
   // Groups 0..9 top, 10..19 bottom, 20 is the side bank clocked by its own line.
   task put(input integer g, input [7:0] d, input s);
      begin
         if (g < 10)
         begin
            dq_top[g*8 +: 8] = d;
            dqs_top[g] = s;
         end
         else if (g < 20)
         begin
            dq_bot[(g-10)*8 +: 8] = d;
            dqs_bot[g-10] = s;
         end
         else
         begin
            dq_side = d;
            ref_clk_side = s;
         end
      end
   endtask
   // Data changes with each strobe edge; the strobe idles low between bursts.
   task burst(input integer g, input integer n, input [7:0] s);
      integer   i;
      reg [7:0] b;
      begin
         for (i = 0; i < n; i = i + 1)
         begin
            b = s + i[7:0];
            put(g, b, 1'b1);
            repeat (4) @(negedge core_clk);
            put(g, ~b, 1'b0);
            repeat (4) @(negedge core_clk);
         end
         put(g, b, 1'b0);
      end
   endtask
endmodule

// file: test/dsps_top_tb_top.sv
`timescale 1ns/1ps
module dsps_top_tb_top;
   reg         core_clk;
   reg         resetn;
   reg         ref_clk_top;
   reg         ref_clk_bot;
   reg         run_top;
   reg         run_bot;
   reg  [4:0]  grp_sel;
   reg         out_ready;
   wire        out_valid;
   wire [15:0] out_data;
   wire        cap_ready_q;
   wire        overflow_q;
   wire        lock_top_q;
   wire        lock_bot_q;
   wire [4:0]  code_top_q;
   wire [4:0]  code_bot_q;
   wire [9:0]  dqs_top;
   wire [9:0]  dqs_bot;
   wire [79:0] dq_top;
   wire [79:0] dq_bot;
   wire [7:0]  dq_side;
   wire        ref_clk_side;
   integer     errors;
   integer     n_checks;
   dsps_top u_dsps_top (
      .core_clk, .resetn, .ref_clk_top, .ref_clk_bot, .ref_clk_side,
      .shift_top_deg (9'h05a), .shift_bot_deg (9'h048),
      .dqs_top, .dqs_bot, .dq_top, .dq_bot, .dq_side, .grp_sel,
      .out_valid, .out_ready, .out_data, .cap_ready_q, .overflow_q,
      .lock_top_q, .lock_bot_q, .code_top_q, .code_bot_q
   );
   dsps_mem u_dsps_mem (
      .core_clk, .dqs_top, .dqs_bot, .dq_top, .dq_bot, .dq_side, .ref_clk_side
   );
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Reference clocks stand low until enabled; their phase is unrelated to core_clk.
   initial
   begin
      ref_clk_top = 1'b0;
      #3;
      forever #80 ref_clk_top = run_top & ~ref_clk_top;
   end
   initial
   begin
      ref_clk_bot = 1'b0;
      #7;
      forever #80 ref_clk_bot = run_bot & ~ref_clk_bot;
   end
   task summarize;
      begin
         if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task cmp_w(input [15:0] g, input [15:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e)
         begin
            errors = errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task cmp_f(input logic g, input logic e);
      begin
         cmp_w({15'h0000, g}, {15'h0000, e});
      end
   endtask
   task get_word(output [15:0] w);
      integer i;
      begin
         i = 0;
         while (out_valid !== 1'b1 && i < 400)
         begin
            @(negedge core_clk);
            i = i + 1;
         end
         if (i == 400)
         begin
            errors = errors + 1;
            summarize;
         end
         w = out_data;
         out_ready = 1'b1;
         @(negedge core_clk);
         out_ready = 1'b0;
         @(negedge core_clk);
      end
   endtask
   task wait_lock(input bot);
      integer i;
      begin
         i = 0;
         while ((bot ? lock_bot_q : lock_top_q) !== 1'b1 && i < 2200)
         begin
            @(negedge core_clk);
            i = i + 1;
         end
         if (i == 2200)
         begin
            errors = errors + 1;
            summarize;
         end
      end
   endtask
   task t_reset;
      begin
         cmp_w({11'h000, code_top_q}, 16'h0008);
         cmp_w({11'h000, code_bot_q}, 16'h0008);
         repeat (3) @(negedge core_clk);
         cmp_f(lock_top_q, 1'b0);
         cmp_f(cap_ready_q, 1'b1);
      end
   endtask
   task t_side;
      reg [15:0] w;
      begin
         grp_sel = 5'h14;
         u_dsps_mem.burst(20, 1, 8'ha5);
         get_word(w);
         cmp_w(w, 16'ha55a);
      end
   endtask
   // An unlocked edge must not capture anything.
   task t_gate;
      integer i;
      reg     seen;
      begin
         seen = 1'b0;
         grp_sel = 5'h00;
         u_dsps_mem.burst(0, 1, 8'h11);
         for (i = 0; i < 60; i = i + 1)
         begin
            @(negedge core_clk);
            if (out_valid === 1'b1)
               seen = 1'b1;
         end
         cmp_f(seen, 1'b0);
      end
   endtask
   task t_lock;
      begin
         run_top = 1'b1;
         wait_lock(1'b0);
         cmp_f(lock_top_q, 1'b1);
         cmp_f(lock_bot_q, 1'b0);
         cmp_f(code_top_q == 5'h07 || code_top_q == 5'h08, 1'b1);
         run_bot = 1'b1;
         wait_lock(1'b1);
         cmp_f(lock_bot_q, 1'b1);
         cmp_f(code_bot_q == 5'h07 || code_bot_q == 5'h08, 1'b1);
      end
   endtask
   task t_groups;
      integer    g;
      reg [7:0]  b;
      reg [15:0] w;
      begin
         for (g = 0; g < 20; g = g + 1)
         begin
            grp_sel = g[4:0];
            b = g[7:0];
            u_dsps_mem.burst(g, 2, b);
            get_word(w);
            cmp_w(w, {b, ~b});
            get_word(w);
            cmp_w(w, {b + 8'h01, ~(b + 8'h01)});
         end
      end
   endtask
   task t_fill;
      integer    i;
      reg [7:0]  b;
      reg [15:0] w;
      begin
         grp_sel = 5'h14;
         u_dsps_mem.burst(20, 33, 8'h40);
         repeat (8) @(negedge core_clk);
         cmp_f(cap_ready_q, 1'b0);
         cmp_f(overflow_q, 1'b1);
         for (i = 0; i < 32; i = i + 1)
         begin
            get_word(w);
            b = 8'h40 + i[7:0];
            cmp_w(w, {b, ~b});
         end
         repeat (20) @(negedge core_clk);
         cmp_f(out_valid, 1'b0);
      end
   endtask
   initial
   begin
      errors = 0;
      n_checks = 0;
      resetn = 1'b0;
      run_top = 1'b0;
      run_bot = 1'b0;
      grp_sel = 5'h14;
      out_ready = 1'b0;
      repeat (20) @(negedge core_clk);
      resetn = 1'b1;
      t_reset;
      t_side;
      t_gate;
      t_lock;
      t_groups;
      t_fill;
      summarize;
   end
endmodule

// file: verilog/dsps_map.vh
// Summary of operation
// RULE1: Top and bottom strobe capture to 200 MHz, data groups eight, sixteen or 32 wide.
// RULE2: Side banks capture data without phase shift and ignore any read strobe.
// RULE3: Every strobe passes a compensated delay that centres it in its data window.
// RULE4: Delayed strobes form a local strobe bus that times the data capture registers.
// RULE5: Top and bottom reference circuits each run from a reference clock at strobe rate.
// RULE6: Top circuit uses the top reference clock, bottom circuit the bottom one.
// RULE7: Each reference circuit sets all ten strobe delays of its edge alike.
// RULE8: Top and bottom phase shift angles are set independently.
// RULE9: Each reference circuit finds its delay setting within 256 reference cycles.
// RULE10: Phase compare delayed reference, step up/down counter, broadcast the code.
`ifndef DSPS_MAP_VH
`define DSPS_MAP_VH

// =====================================================================
// Sizes
`define DSPS_NUM_DQS       10
`define DSPS_DQ_W          8
`define DSPS_CODE_W        5
`define DSPS_HIST          32
`define DSPS_DEG_W         9
`define DSPS_SEL_W         5
`define DSPS_FIFO_DEPTH    32
`define DSPS_FIFO_AW       5

// =====================================================================
// Reset values and timing
`define DSPS_CODE_RST      5'h08
`define DSPS_LOCK_REF_CYC  9'h100
`define DSPS_DEG_FULL      9'h168
`define DSPS_MAX_STROBE_MHZ 200
`define DSPS_CORE_MHZ      50

// =====================================================================
// Synchroniser bit positions
`define DSPS_SY_REF_TOP    0
`define DSPS_SY_REF_BOT    1
`define DSPS_SY_REF_SIDE   2
`define DSPS_SY_DQS        3

`endif

// file: verilog/dsps_top.v
`timescale 1ns/1ps
`include "dsps_map.vh"

// =====================================================================
// Capture FIFO with a registered output stage
module dsps_fifo #(
   parameter W     = 16,
   parameter DEPTH = `DSPS_FIFO_DEPTH,
   parameter AW    = `DSPS_FIFO_AW
)(
   input  wire          clk,
   input  wire          resetn,
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   output reg           out_valid,
   input  wire          out_ready,
   output reg  [W-1:0]  out_data
);
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];
   reg  [W-1:0]  mem [0:DEPTH-1];
   reg  [AW-1:0] wr_ptr_q;
   reg  [AW-1:0] rd_ptr_q;
   reg  [AW:0]   cnt_q;
   wire          wr_en;
   wire          ld_en;

   // The output register is one of the DEPTH words, so it counts towards full.
   assign in_ready = ((cnt_q + {{AW{1'b0}}, out_valid}) != FULL_CNT);
   assign wr_en    = in_valid & in_ready;
   assign ld_en    = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

   always @(posedge clk)
   begin
      if (!resetn)
      begin
         wr_ptr_q  <= {AW{1'b0}};
         rd_ptr_q  <= {AW{1'b0}};
         cnt_q     <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {W{1'b0}};
      end
      else
      begin
         if (wr_en)
         begin
            mem[wr_ptr_q] <= in_data;
            wr_ptr_q      <= wr_ptr_q + 1'b1;
         end
         if (ld_en)
         begin
            rd_ptr_q  <= rd_ptr_q + 1'b1;
            out_data  <= mem[rd_ptr_q];
            out_valid <= 1'b1;
         end
         else if (out_ready)
            out_valid <= 1'b0;
         if (wr_en & ~ld_en)
            cnt_q <= cnt_q + 1'b1;
         else if (ld_en & ~wr_en)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// =====================================================================
// Strobe phase shift and capture, top, bottom and side banks
module dsps_top #(
   parameter NUM_DQS = `DSPS_NUM_DQS,
   parameter DQ_W    = `DSPS_DQ_W,
   parameter CODE_W  = `DSPS_CODE_W,
   parameter HIST    = `DSPS_HIST,
   parameter DEPTH   = `DSPS_FIFO_DEPTH,
   parameter AW      = `DSPS_FIFO_AW
)(
   input  wire                      core_clk,
   input  wire                      resetn,
   input  wire                      ref_clk_top,
   input  wire                      ref_clk_bot,
   input  wire                      ref_clk_side,
   input  wire [`DSPS_DEG_W-1:0]    shift_top_deg,
   input  wire [`DSPS_DEG_W-1:0]    shift_bot_deg,
   input  wire [NUM_DQS-1:0]        dqs_top,
   input  wire [NUM_DQS-1:0]        dqs_bot,
   input  wire [NUM_DQS*DQ_W-1:0]   dq_top,
   input  wire [NUM_DQS*DQ_W-1:0]   dq_bot,
   input  wire [DQ_W-1:0]           dq_side,
   input  wire [`DSPS_SEL_W-1:0]    grp_sel,
   output wire                      out_valid,
   input  wire                      out_ready,
   output wire [2*DQ_W-1:0]         out_data,
   output reg                       cap_ready_q,
   output reg                       overflow_q,
   output reg                       lock_top_q,
   output reg                       lock_bot_q,
   output reg  [CODE_W-1:0]         code_top_q,
   output reg  [CODE_W-1:0]         code_bot_q
);
   localparam NGRP   = 2*NUM_DQS;
   localparam DQ_POS = `DSPS_SY_DQS + NGRP;
   localparam SW     = DQ_POS + (NGRP+1)*DQ_W;
   localparam WW     = 2*DQ_W;

   // Tap for a strobe: fraction deg/360 of the full-period code.
   function [CODE_W-1:0] calc_tap;
      input [CODE_W-1:0]      code;
      input [`DSPS_DEG_W-1:0] deg;
      reg   [CODE_W+`DSPS_DEG_W-1:0] prod;
      begin
         prod     = code * deg;
         prod     = prod / `DSPS_DEG_FULL;
         calc_tap = prod[CODE_W-1:0];
      end
   endfunction

   // ==================================================================
   // Pin synchronisers: three flops, a change counts when two and three agree
   wire [SW-1:0] pins;
   reg  [SW-1:0] sy1_q;
   reg  [SW-1:0] sy2_q;
   reg  [SW-1:0] sy3_q;
   reg  [SW-1:0] lvl_q;

   assign pins = {dq_side, dq_bot, dq_top, dqs_bot, dqs_top,
                  ref_clk_side, ref_clk_bot, ref_clk_top};

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         sy1_q <= {SW{1'b0}};
         sy2_q <= {SW{1'b0}};
         sy3_q <= {SW{1'b0}};
         lvl_q <= {SW{1'b0}};
      end
      else
      begin
         sy1_q <= pins;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         lvl_q <= (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & lvl_q);
      end
   end

   // ==================================================================
   // Reference circuits, one per edge
   reg  [2*HIST-1:0]   ref_hist_q;
   reg  [2*CODE_W-1:0] code_q;
   reg  [1:0]          lock_q;
   reg  [2*CODE_W-1:0] tap_q;
   wire [2*`DSPS_DEG_W-1:0] deg_all;

   assign deg_all = {shift_bot_deg, shift_top_deg};

   genvar e;
   generate
      for (e = 0; e < 2; e = e + 1)
      begin : g_ref
         reg  [8:0]        nref_q;
         reg               dir_q;
         reg               stepped_q;
         wire              lvl;
         wire              rise;
         wire              dly;
         wire [CODE_W-1:0] code;

         assign lvl  = lvl_q[`DSPS_SY_REF_TOP + e]; //RULE6
         assign rise = lvl & ~ref_hist_q[e*HIST];
         assign code = code_q[e*CODE_W +: CODE_W];
         assign dly  = ref_hist_q[e*HIST + code]; //RULE10

         always @(posedge core_clk)
         begin
            if (!resetn)
            begin
               ref_hist_q[e*HIST +: HIST]  <= {HIST{1'b0}};
               code_q[e*CODE_W +: CODE_W]  <= `DSPS_CODE_RST;
               tap_q[e*CODE_W +: CODE_W]   <= {CODE_W{1'b0}};
               lock_q[e]                   <= 1'b0;
               nref_q                      <= 9'h000;
               dir_q                       <= 1'b0;
               stepped_q                   <= 1'b0;
            end
            else
            begin
               ref_hist_q[e*HIST +: HIST] <= {ref_hist_q[e*HIST +: HIST-1], lvl}; //RULE5
               tap_q[e*CODE_W +: CODE_W] <=
                  calc_tap(code, deg_all[e*`DSPS_DEG_W +: `DSPS_DEG_W]); //RULE8
               if (rise)
               begin
                  // A high delayed copy at the reference edge means too little delay.
                  if (dly && code != {CODE_W{1'b1}})
                     code_q[e*CODE_W +: CODE_W] <= code + 1'b1; //RULE10
                  else if (!dly && code != {CODE_W{1'b0}})
                     code_q[e*CODE_W +: CODE_W] <= code - 1'b1; //RULE10
                  dir_q     <= dly;
                  stepped_q <= 1'b1;
                  if (nref_q != `DSPS_LOCK_REF_CYC)
                     nref_q <= nref_q + 1'b1;
                  if ((stepped_q && dir_q != dly) ||
                      nref_q == `DSPS_LOCK_REF_CYC - 9'h001)
                     lock_q[e] <= 1'b1; //RULE9
               end
            end
         end
      end
   endgenerate

   // ==================================================================
   // Delayed strobe bus and DDR capture per group
   reg  [NGRP*HIST-1:0] dqs_hist_q;
   reg  [NGRP-1:0]      ds_prev_q;
   reg  [NGRP*DQ_W-1:0] rise_q;
   reg  [NGRP*WW-1:0]   word_q;
   reg  [NGRP:0]        wvld_q;
   reg  [DQ_W-1:0]      side_rise_q;
   reg  [WW-1:0]        side_word_q;
   reg                  side_prev_q;

   genvar g;
   generate
      for (g = 0; g < NGRP; g = g + 1)
      begin : g_cap
         wire [CODE_W-1:0] tap;
         wire              ds;
         wire [DQ_W-1:0]   dq;

         assign tap = tap_q[(g/NUM_DQS)*CODE_W +: CODE_W]; //RULE7
         assign ds  = dqs_hist_q[g*HIST + tap]; //RULE3
         assign dq  = lvl_q[DQ_POS + g*DQ_W +: DQ_W];

         always @(posedge core_clk)
         begin
            if (!resetn)
            begin
               dqs_hist_q[g*HIST +: HIST] <= {HIST{1'b0}};
               ds_prev_q[g]               <= 1'b0;
               rise_q[g*DQ_W +: DQ_W]     <= {DQ_W{1'b0}};
               word_q[g*WW +: WW]         <= {WW{1'b0}};
               wvld_q[g]                  <= 1'b0;
            end
            else
            begin
               dqs_hist_q[g*HIST +: HIST] <=
                  {dqs_hist_q[g*HIST +: HIST-1], lvl_q[`DSPS_SY_DQS + g]}; //RULE3
               ds_prev_q[g] <= ds;
               wvld_q[g]    <= 1'b0;
               if (ds & ~ds_prev_q[g])
                  rise_q[g*DQ_W +: DQ_W] <= dq; //RULE4
               if (~ds & ds_prev_q[g])
               begin
                  word_q[g*WW +: WW] <= {rise_q[g*DQ_W +: DQ_W], dq}; //RULE4
                  wvld_q[g]          <= lock_q[g/NUM_DQS];
               end
            end
         end
      end
   endgenerate

   // Side banks: timed by the side reference clock, no strobe at all.
   wire side_lvl;
   assign side_lvl = lvl_q[`DSPS_SY_REF_SIDE];

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         side_prev_q  <= 1'b0;
         side_rise_q  <= {DQ_W{1'b0}};
         side_word_q  <= {WW{1'b0}};
         wvld_q[NGRP] <= 1'b0;
      end
      else
      begin
         side_prev_q  <= side_lvl;
         wvld_q[NGRP] <= 1'b0;
         if (side_lvl & ~side_prev_q)
            side_rise_q <= lvl_q[SW-DQ_W +: DQ_W]; //RULE2
         if (~side_lvl & side_prev_q)
         begin
            side_word_q  <= {side_rise_q, lvl_q[SW-DQ_W +: DQ_W]}; //RULE2
            wvld_q[NGRP] <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Group select into the capture FIFO
   wire [(NGRP+1)*WW-1:0] all_words;
   reg                    push_vld_q;
   reg  [WW-1:0]          push_data_q;
   wire                   fifo_in_ready;

   assign all_words = {side_word_q, word_q};

   always @(posedge core_clk)
   begin
      if (!resetn)
      begin
         push_vld_q  <= 1'b0;
         push_data_q <= {WW{1'b0}};
         overflow_q  <= 1'b0;
         cap_ready_q <= 1'b0;
         lock_top_q  <= 1'b0;
         lock_bot_q  <= 1'b0;
         code_top_q  <= `DSPS_CODE_RST;
         code_bot_q  <= `DSPS_CODE_RST;
      end
      else
      begin
         push_vld_q  <= (grp_sel <= NGRP) ? wvld_q[grp_sel] : 1'b0; //RULE1
         push_data_q <= all_words[grp_sel*WW +: WW];
         if (push_vld_q & ~fifo_in_ready)
            overflow_q <= 1'b1;
         cap_ready_q <= fifo_in_ready;
         lock_top_q  <= lock_q[0];
         lock_bot_q  <= lock_q[1];
         code_top_q  <= code_q[0 +: CODE_W];
         code_bot_q  <= code_q[CODE_W +: CODE_W];
      end
   end

   dsps_fifo #(
      .W     (WW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_fifo (
      .clk       (core_clk),
      .resetn    (resetn),
      .in_valid  (push_vld_q),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data_q),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data)
   );
endmodule
